// ===== hw/fie_defines.svh
// register indices, field positions and reset values of the fault enable bank
`ifndef FIE_DEFINES_SVH
`define FIE_DEFINES_SVH

// register indices; the byte address on the bus is four times the index
`define FIE_SUPPLY_EN_IDX     8'h08
`define FIE_BOOST_EN_IDX      8'h0a
`define FIE_SUPPLY_STAT_IDX   8'h0e
`define FIE_BOOST_STAT_IDX    8'h10

// reset values
`define FIE_SUPPLY_EN_RST     16'h2aaa
`define FIE_BOOST_EN_RST      16'ha028
`define FIE_STAT_RST          16'h0000

// lsb of each two-bit enable field, supply register
`define FIE_BOOST_SYNC_LSB    13'd12
`define FIE_CHARGE_PUMP_LSB   13'd10
`define FIE_PUMP_CAP_LSB      13'd8
`define FIE_IN_OVERCUR_LSB    13'd6
`define FIE_INT_SUPPLY_UV_LSB 13'd4
`define FIE_IN_OVERVOLT_LSB   13'd2
`define FIE_IN_UNDERVOLT_LSB  13'd0

// lsb of each two-bit enable field, boost register
`define FIE_OVERTEMP_LSB      13'd14
`define FIE_ISET_SHORT_LSB    13'd12
`define FIE_STRING_CFG_LSB    13'd10
`define FIE_MODE_RES_LSB      13'd8
`define FIE_FREQ_RES_LSB      13'd6
`define FIE_BOOST_OVERCUR_LSB 13'd4
`define FIE_BOOST_OVERVOLT_LSB 13'd2

// first field of each register, used by the packing loops
`define FIE_SUPPLY_BASE_LSB   0
`define FIE_BOOST_BASE_LSB    2

`endif

// ===== hw/fie_pkg.sv
// types shared by the fault enable bank
package fie_pkg;

  // two-bit write code of an enable field
  typedef enum logic [1:0] {
    FIE_CODE_HOLD_LOW,
    FIE_CODE_OFF,
    FIE_CODE_HOLD_HIGH,
    FIE_CODE_ON
  } fie_en_code_t;

  typedef logic [15:0] fie_reg_t;
  typedef logic [7:0]  fie_idx_t;

endpackage : fie_pkg

// ===== hw/fie_enable_field.sv
// one two-bit interrupt enable field with write-code semantics
`timescale 1ns/1ns
module fie_enable_field #(
  parameter logic RESET_ON = 1'b1
) (
  input  wire logic                 clock_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 write_i,
  input  wire fie_pkg::fie_en_code_t code_i,
  output logic                      enabled_o
);
  import fie_pkg::*;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      enabled_o <= RESET_ON;
    else if (write_i)
    begin
      case (code_i)
        FIE_CODE_OFF: enabled_o <= 1'b0;
        FIE_CODE_ON:  enabled_o <= 1'b1;
        // other codes keep the field so one field can change alone
        default:      enabled_o <= enabled_o;
      endcase
    end
  end

endmodule : fie_enable_field

// ===== hw/fie_fault_latch.sv
// sticky status of one fault source
`timescale 1ns/1ns
module fie_fault_latch (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic fault_i,
  input  wire logic clear_i,
  output logic      status_o
);

  // a fault in the cycle of a clear wins, so no event is lost
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      status_o <= 1'b0;
    else if (fault_i)
      status_o <= 1'b1;
    else if (clear_i)
      status_o <= 1'b0;
  end

endmodule : fie_fault_latch

// ===== hw/fie_top.sv
// fault interrupt enable bank with ahb-lite register slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "fie_defines.svh"

module fie_top #(
  parameter int NUM_SUPPLY = 7,
  parameter int NUM_BOOST  = 7
) (
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // ahb-lite slave
  input  wire logic              hsel_i,
  input  wire logic [9:0]        haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic [31:0]            hrdata_o,
  // fault sources, active high levels
  input  wire logic              boost_sync_loss_fault_i,
  input  wire logic              charge_pump_fault_i,
  input  wire logic              pump_capacitor_missing_fault_i,
  input  wire logic              input_overcurrent_fault_i,
  input  wire logic              internal_supply_undervoltage_fault_i,
  input  wire logic              input_overvoltage_fault_i,
  input  wire logic              input_undervoltage_fault_i,
  input  wire logic              overtemp_fault_i,
  input  wire logic              current_resistor_short_fault_i,
  input  wire logic              string_config_resistor_fault_i,
  input  wire logic              mode_select_resistor_fault_i,
  input  wire logic              freq_resistor_missing_fault_i,
  input  wire logic              boost_overcurrent_fault_i,
  input  wire logic              boost_overvoltage_fault_i,
  // interrupt request, active high level
  output logic                   irq_o
);
  import fie_pkg::*;

  localparam fie_reg_t SUP_RST = `FIE_SUPPLY_EN_RST;
  localparam fie_reg_t BST_RST = `FIE_BOOST_EN_RST;
  localparam int       SUP_LSB = `FIE_SUPPLY_BASE_LSB;
  localparam int       BST_LSB = `FIE_BOOST_BASE_LSB;

  logic [NUM_SUPPLY-1:0] sup_fault;
  logic [NUM_SUPPLY-1:0] sup_en;
  logic [NUM_SUPPLY-1:0] sup_stat;
  logic [NUM_SUPPLY-1:0] sup_clr;
  logic [NUM_BOOST-1:0]  bst_fault;
  logic [NUM_BOOST-1:0]  bst_en;
  logic [NUM_BOOST-1:0]  bst_stat;
  logic [NUM_BOOST-1:0]  bst_clr;
  fie_reg_t              sup_en_img;
  fie_reg_t              bst_en_img;
  fie_reg_t              sup_stat_img;
  fie_reg_t              bst_stat_img;
  logic                  acc;
  logic                  wr_pend;
  logic                  rd_late;
  fie_idx_t              idx;
  logic                  wr_sup_en;
  logic                  wr_bst_en;
  logic                  wr_sup_stat;
  logic                  wr_bst_stat;
  logic                  next_irq;

  // field order is lsb first: index i sits at bits 2i+1:2i above the base
  assign sup_fault[0] = input_undervoltage_fault_i;
  assign sup_fault[1] = input_overvoltage_fault_i;
  assign sup_fault[2] = internal_supply_undervoltage_fault_i;
  assign sup_fault[3] = input_overcurrent_fault_i;
  assign sup_fault[4] = pump_capacitor_missing_fault_i;
  assign sup_fault[5] = charge_pump_fault_i;
  assign sup_fault[6] = boost_sync_loss_fault_i;

  assign bst_fault[0] = boost_overvoltage_fault_i;
  assign bst_fault[1] = boost_overcurrent_fault_i;
  assign bst_fault[2] = freq_resistor_missing_fault_i;
  assign bst_fault[3] = mode_select_resistor_fault_i;
  assign bst_fault[4] = string_config_resistor_fault_i;
  assign bst_fault[5] = current_resistor_short_fault_i;
  assign bst_fault[6] = overtemp_fault_i;

  // write strobes land in the data phase, when hwdata is on the bus
  assign wr_sup_en   = wr_pend && (idx == `FIE_SUPPLY_EN_IDX);
  assign wr_bst_en   = wr_pend && (idx == `FIE_BOOST_EN_IDX);
  assign wr_sup_stat = wr_pend && (idx == `FIE_SUPPLY_STAT_IDX);
  assign wr_bst_stat = wr_pend && (idx == `FIE_BOOST_STAT_IDX);

  // unused image bits default to zero, which keeps reserved bits clear
  always_comb
  begin
    sup_en_img   = '0;
    bst_en_img   = '0;
    sup_stat_img = '0;
    bst_stat_img = '0;
    for (int i = 0; i < NUM_SUPPLY; i++)
    begin
      sup_en_img[SUP_LSB+2*i+1]   = sup_en[i];
      sup_stat_img[SUP_LSB+2*i+1] = sup_stat[i];
    end
    for (int i = 0; i < NUM_BOOST; i++)
    begin
      bst_en_img[BST_LSB+2*i+1]   = bst_en[i];
      bst_stat_img[BST_LSB+2*i+1] = bst_stat[i];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SUPPLY; g++)
    begin : g_sup
      // reset state of each field taken from the register reset value
      fie_enable_field #(
        .RESET_ON (SUP_RST[SUP_LSB+2*g+1])
      ) u_en (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .write_i   (wr_sup_en),
        .code_i    (fie_en_code_t'(hwdata_i[SUP_LSB+2*g +: 2])),
        .enabled_o (sup_en[g])
      );
      // clearing needs both the status and the clear bit written as one
      assign sup_clr[g] = wr_sup_stat
                          && (hwdata_i[SUP_LSB+2*g +: 2] == 2'h3);
      fie_fault_latch u_stat (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .fault_i   (sup_fault[g]),
        .clear_i   (sup_clr[g]),
        .status_o  (sup_stat[g])
      );
    end
    for (g = 0; g < NUM_BOOST; g++)
    begin : g_bst
      fie_enable_field #(
        .RESET_ON (BST_RST[BST_LSB+2*g+1])
      ) u_en (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .write_i   (wr_bst_en),
        .code_i    (fie_en_code_t'(hwdata_i[BST_LSB+2*g +: 2])),
        .enabled_o (bst_en[g])
      );
      assign bst_clr[g] = wr_bst_stat
                          && (hwdata_i[BST_LSB+2*g +: 2] == 2'h3);
      fie_fault_latch u_stat (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .fault_i   (bst_fault[g]),
        .clear_i   (bst_clr[g]),
        .status_o  (bst_stat[g])
      );
    end
  endgenerate

  function automatic logic [31:0] read_mux(input fie_idx_t ridx);
    if (ridx == `FIE_SUPPLY_EN_IDX)
      read_mux = {16'h0000, sup_en_img};
    else if (ridx == `FIE_BOOST_EN_IDX)
      read_mux = {16'h0000, bst_en_img};
    else if (ridx == `FIE_SUPPLY_STAT_IDX)
      read_mux = {16'h0000, sup_stat_img};
    else if (ridx == `FIE_BOOST_STAT_IDX)
      read_mux = {16'h0000, bst_stat_img};
    else
      read_mux = 32'h0000_0000;
  endfunction : read_mux

  assign acc = hsel_i && htrans_i[1] && hready_i;

  // a read right behind a write gets one wait state so it sees the new data
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      wr_pend     <= 1'b0;
      rd_late     <= 1'b0;
      idx         <= 8'h00;
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend     <= acc && hwrite_i;
      rd_late     <= 1'b0;
      hreadyout_o <= 1'b1;
      if (acc)
        idx <= haddr_i[9:2];
      if (acc && !hwrite_i)
      begin
        if (wr_pend)
        begin
          rd_late     <= 1'b1;
          hreadyout_o <= 1'b0;
        end
        else
          hrdata_o <= read_mux(haddr_i[9:2]);
      end
      else if (rd_late)
        hrdata_o <= read_mux(idx);
    end
  end

  // every transfer is answered okay; unmapped reads return zero
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      hresp_o <= 1'b0;
    else
      hresp_o <= 1'b0;
  end

  assign next_irq = |(sup_stat & sup_en) || |(bst_stat & bst_en);

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= next_irq;
  end

  property p_field_off;
    @(posedge clock_i) disable iff (sys_rst_i)
    (wr_sup_en && hwdata_i[1:0] == 2'h1) |=> !sup_en[0];
  endproperty
  a_field_off: assert property (p_field_off)
    else $error("supply field did not disable on code 1");

  property p_field_on;
    @(posedge clock_i) disable iff (sys_rst_i)
    (wr_bst_en && hwdata_i[15:14] == 2'h3) |=> bst_en_img[15:14] == 2'h2;
  endproperty
  a_field_on: assert property (p_field_on)
    else $error("boost field did not enable on code 3");

  property p_keep;
    @(posedge clock_i) disable iff (sys_rst_i)
    (wr_sup_en && !hwdata_i[2]) |=> $stable(sup_en[1]);
  endproperty
  a_keep: assert property (p_keep)
    else $error("field changed on a keep code");

  property p_read_code;
    @(posedge clock_i) disable iff (sys_rst_i)
    (acc && !hwrite_i && !wr_pend && haddr_i[9:2] == `FIE_BOOST_EN_IDX)
      |=> hrdata_o[15:14] == {$past(bst_en[6]), 1'b0};
  endproperty
  a_read_code: assert property (p_read_code)
    else $error("enable field read code wrong");

  property p_sup_reset;
    @(posedge clock_i)
    $past(sys_rst_i) |-> sup_en_img == `FIE_SUPPLY_EN_RST;
  endproperty
  a_sup_reset: assert property (p_sup_reset)
    else $error("supply enable reset value wrong");

  property p_bst_reset;
    @(posedge clock_i)
    $past(sys_rst_i) |-> bst_en_img == `FIE_BOOST_EN_RST;
  endproperty
  a_bst_reset: assert property (p_bst_reset)
    else $error("boost enable reset value wrong");

  property p_reserved;
    @(posedge clock_i) disable iff (sys_rst_i)
    sup_en_img[15:14] == 2'h0 && bst_en_img[1:0] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved enable bits not zero");

  property p_irq_gate;
    @(posedge clock_i) disable iff (sys_rst_i)
    (sup_stat[6] && !sup_en[6] && !(|(sup_stat[5:0] & sup_en[5:0]))
      && !(|(bst_stat & bst_en))) |=> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("disabled fault drove the interrupt");

  property p_irq_fire;
    @(posedge clock_i) disable iff (sys_rst_i)
    (overtemp_fault_i && bst_en[6]) |=> ##1 irq_o;
  endproperty
  a_irq_fire: assert property (p_irq_fire)
    else $error("enabled fault missed the interrupt");

  property p_record;
    @(posedge clock_i) disable iff (sys_rst_i)
    (mode_select_resistor_fault_i && !bst_en[3]) |=> bst_stat[3];
  endproperty
  a_record: assert property (p_record)
    else $error("fault not recorded while disabled");

  property p_irq_on;
    @(posedge clock_i) disable iff (sys_rst_i)
    (|(sup_stat & sup_en)) |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled supply fault missed the interrupt");

  // enables may only move on a register write, never on their own
  property p_en_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
    (!wr_sup_en && !wr_bst_en) |=> ($stable(sup_en) && $stable(bst_en));
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("enable changed without a register write");

endmodule : fie_top

// ===== bench/fie_host_model.sv
// host-side ahb-lite master model that reaches the enable bank registers
`timescale 1ns/1ns
module fie_host_model (
  input  wire logic        clock_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [9:0]       haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  initial
  begin
    hsel_o   = 1'b0;
    haddr_o  = 10'h000;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0000_0000;
  end

  // no fixed latency assumed: wait for the slave, but never forever
  task wait_ready;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clock_i);
      if (hready_i === 1'b1)
        return;
    end
    tb_top.n_errors++;
    $display("[FAIL] %0t bus answer never came", $time);
    tb_top.conclude();
  endtask : wait_ready

  task addr_phase(input logic [9:0] addr, input logic wr);
    hsel_o   <= 1'b1;
    haddr_o  <= addr;
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o  <= 3'h2;
    wait_ready();
    htrans_o <= 2'b00;
  endtask : addr_phase

  task bus_write(input logic [9:0] addr, input logic [31:0] data);
    addr_phase(addr, 1'b1);
    hwdata_o <= data;
    wait_ready();
    // stale write data would hide a slave sampling one cycle late
    hwdata_o <= ~data;
  endtask : bus_write

  task bus_read(input logic [9:0] addr, output logic [31:0] data);
    addr_phase(addr, 1'b0);
    wait_ready();
    data = hrdata_i;
  endtask : bus_read

  // status and clear bit of one pair go together in a single write
  task bus_clear(input logic [9:0] addr, input int field);
    bus_write(addr, 32'h3 << (2 * field));
  endtask : bus_clear
endmodule : fie_host_model

// ===== bench/tb_top.sv
// self-checking bench for the fault interrupt enable bank
`timescale 1ns/1ns
module tb_top;
  logic        clock_i;
  logic        sys_rst_i;
  logic        hsel;
  logic [9:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [13:0] flt;
  logic        irq;
  logic [31:0] rd;
  logic [15:0] exp_en [2];
  int          n_errors;
  int          checks_done;

  fie_top u_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .input_undervoltage_fault_i(flt[0]),
    .input_overvoltage_fault_i(flt[1]),
    .internal_supply_undervoltage_fault_i(flt[2]),
    .input_overcurrent_fault_i(flt[3]),
    .pump_capacitor_missing_fault_i(flt[4]),
    .charge_pump_fault_i(flt[5]),
    .boost_sync_loss_fault_i(flt[6]),
    .boost_overvoltage_fault_i(flt[7]),
    .boost_overcurrent_fault_i(flt[8]),
    .freq_resistor_missing_fault_i(flt[9]),
    .mode_select_resistor_fault_i(flt[10]),
    .string_config_resistor_fault_i(flt[11]),
    .current_resistor_short_fault_i(flt[12]),
    .overtemp_fault_i(flt[13]),
    .irq_o(irq)
  );

  fie_host_model u_host (
    .clock_i(clock_i), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task conclude;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // field codes 1 and 3 act, 0 and 2 keep; reserved pairs never change
  function automatic logic [15:0] upd(input logic [15:0] old,
                                      input logic [31:0] w,
                                      input logic [15:0] m);
    logic [15:0] r;
    r = old;
    for (int i = 0; i < 8; i++)
      if (m[2*i] && w[2*i+:2] == 2'd1)
        r[2*i+:2] = 2'b00;
      else if (m[2*i] && w[2*i+:2] == 2'd3)
        r[2*i+:2] = 2'b10;
    return r;
  endfunction : upd

  task wr_en(input int r, input logic [31:0] d);
    u_host.bus_write(r ? 10'h028 : 10'h020, d);
    exp_en[r] = upd(exp_en[r], d, r ? 16'hfffc : 16'h3fff);
    u_host.bus_read(r ? 10'h028 : 10'h020, rd);
    check(rd, {16'h0000, exp_en[r]}, "enable readback");
  endtask : wr_en

  task do_reset;
    sys_rst_i <= 1'b1;
    flt       <= 14'h0000;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    exp_en[0] = 16'h2aaa;
    exp_en[1] = 16'ha028;
    check(32'(irq), 32'h0, "irq after reset");
    u_host.bus_read(10'h020, rd);
    check(rd, 32'h2aaa, "supply reset");
    check(32'(hresp), 32'h0, "response not okay");
    check(32'(rd[13:6]), 32'haa, "supply hi");
    check(32'(rd[5:0]), 32'h2a, "supply lo");
    u_host.bus_read(10'h028, rd);
    check(rd, 32'ha028, "boost reset");
    check(32'(rd[15:10]), 32'h28, "boost hi");
    check(32'(rd[9:2]), 32'h0a, "boost lo");
  endtask : do_reset

  initial
  begin
    logic [9:0] sa;
    int         r;
    int         f;
    sys_rst_i   = 1'b1;
    flt         = 14'h0000;
    n_errors    = 0;
    checks_done = 0;
    do_reset();
    u_host.bus_write(10'h3fc, 32'hffff_ffff);
    u_host.bus_read(10'h3fc, rd);
    check(rd, 32'h0, "unmapped read");
    for (r = 0; r < 2; r++)
    begin
      wr_en(r, 32'hffff_5555);
      wr_en(r, 32'h0000_aaaa);
      wr_en(r, 32'h0000_0000);
      for (f = 0; f < 8; f++)
        wr_en(r, 32'h3 << (2 * f));
    end
    // each fault: recorded while masked, reaches irq once enabled
    for (int k = 0; k < 14; k++)
    begin
      r  = (k > 6) ? 1 : 0;
      f  = r ? k - 6 : k;
      sa = r ? 10'h040 : 10'h038;
      wr_en(r, 32'h1 << (2 * f));
      flt[k] <= 1'b1;
      @(posedge clock_i);
      flt[k] <= 1'b0;
      repeat (3) @(posedge clock_i);
      #1;
      check(32'(irq), 32'h0, "masked fault raised irq");
      u_host.bus_read(sa, rd);
      check(rd, 32'h2 << (2 * f), "status not kept");
      wr_en(r, 32'h3 << (2 * f));
      repeat (3) @(posedge clock_i);
      #1;
      check(32'(irq), 32'h1, "enabled fault no irq");
      u_host.bus_write(sa, 32'h2 << (2 * f));
      repeat (3) @(posedge clock_i);
      #1;
      check(32'(irq), 32'h1, "status-only write cleared");
      u_host.bus_clear(sa, f);
      repeat (3) @(posedge clock_i);
      #1;
      check(32'(irq), 32'h0, "irq not cleared");
      u_host.bus_read(sa, rd);
      check(rd, 32'h0, "status not cleared");
    end
    // a fault that arrives while its field is already enabled
    flt[13] <= 1'b1;
    @(posedge clock_i);
    flt[13] <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    check(32'(irq), 32'h1, "enabled overtemp no irq");
    u_host.bus_clear(10'h040, 7);
    repeat (3) @(posedge clock_i);
    #1;
    check(32'(irq), 32'h0, "overtemp irq not cleared");
    do_reset();
    conclude();
  end
endmodule : tb_top
